/* File: hdl/scip_core.sv */
// Overview of operation
// - Unmasked event gives one low pulse
// - Init-time config sets pulse mode, width
// - Masked sources never start a pulse
// - Each I/O line state change raises event
// - Each I/O line wake gives own event
// - CAN bus wake raises event
// - Transmit input dominant clamp raises event
// - Receive line recessive clamp raises event
// - Bus dominant clamp raises event
// - Four wire short flags, battery and ground
// - Host command requests an interrupt pulse
// - Main-state frame clock count not sixteen flags error
// - Invalid access raises request error
// - Main-state frame parity mismatch raises event
// - Secured check failure raises event
// - Battery under 8.5V raises event
// - Supply under 7V raises event
// - Limit duration expiry raises event, with external pass device only
// - Bus supply shutdown event, restart auto
// - Buck/boost state reported as source
// - Converter activation states reported
// - Per pass transistor temperature warning
`timescale 1ns/10ps
`default_nettype none
module scip_core
  import scip_pkg::*;
#(
  parameter logic [PULSE_W-1:0] P_PULSE_DEF = PULSE_DEF
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_battery_sense_undervoltage,
  input  wire logic              i_supply_input_low,
  input  wire logic              i_ext_pass_used,
  input  wire logic              i_aux_rail_limit_timeout,
  input  wire logic              i_analog_rail_limit_timeout,
  input  wire logic              i_bus_supply_thermal_shutdown,
  input  wire logic              i_prereg_temp_warning,
  input  wire logic              i_core_reg_temp_warning,
  input  wire logic              i_analog_rail_temp_warning,
  input  wire logic              i_prereg_buck_boost_state,
  input  wire logic              i_prereg_enabled,
  input  wire logic              i_core_reg_enabled,
  input  wire logic              i_bus_wake_event,
  input  wire logic              i_txd_dominant_clamp,
  input  wire logic              i_rxd_recessive_clamp,
  input  wire logic              i_bus_dominant_clamp,
  input  wire logic              i_low_wire_short_battery,
  input  wire logic              i_low_wire_short_ground,
  input  wire logic              i_high_wire_short_battery,
  input  wire logic              i_high_wire_short_ground,
  input  wire logic [NUM_GP-1:0] i_gp_line,
  input  wire logic [NUM_GP-1:0] i_gp_line_wake,
  input  wire logic              i_irq_request,
  input  wire logic              i_frame_done,
  input  wire logic [4:0]        i_frame_clocks,
  input  wire logic              i_main_state,
  input  wire logic              i_parity_bad,
  input  wire logic              i_secure_bad,
  input  wire logic              i_access_bad,
  input  wire logic              i_init_phase,
  input  wire logic              i_cfg_write,
  input  wire logic              i_cfg_disable,
  input  wire logic [PULSE_W-1:0] i_cfg_pulse_len,
  input  wire logic [NUM_EV-1:0] i_mask,
  input  wire logic [NUM_EV-1:0] i_status_read,
  output logic                   o_irq_out_n,
  output logic [NUM_EV-1:0]      o_flags,
  output logic                   o_bus_supply_off
);

  // Positions in the synchronised pin vector
  localparam int AN_BAT_UV   = 0;
  localparam int AN_SUP_LOW  = 1;
  localparam int AN_AUX_TMO  = 2;
  localparam int AN_ANA_TMO  = 3;
  localparam int AN_BUS_TSD  = 4;
  localparam int AN_PRE_TW   = 5;
  localparam int AN_CORE_TW  = 6;
  localparam int AN_ANA_TW   = 7;
  localparam int AN_BOB      = 8;
  localparam int AN_PRE_EN   = 9;
  localparam int AN_CORE_EN  = 10;
  localparam int AN_BUS_WAKE = 11;
  localparam int AN_TXD_DOM  = 12;
  localparam int AN_RXD_REC  = 13;
  localparam int AN_BUS_DOM  = 14;
  localparam int AN_SHORT0   = 15;
  localparam int AN_EXT_PASS = 19;
  localparam int NUM_AN      = 20;
  // Synchroniser fill time; edges seen before it come from reset, not pins
  localparam logic [1:0] WARM_DONE = 2'h3;

  typedef struct packed {
    scip_state_t         st;
    logic [PULSE_W-1:0]  cnt;
    logic [PULSE_W-1:0]  len;
    logic                dis;
    logic [NUM_EV-1:0]   flags;
    logic [NUM_EV-1:0]   pend;
    logic [NUM_GP-1:0]   gp_s1;
    logic [NUM_GP-1:0]   gp_s2;
    logic [NUM_GP-1:0]   gp_old;
    logic [NUM_GP-1:0]   wk_s1;
    logic [NUM_GP-1:0]   wk_s2;
    logic [NUM_GP-1:0]   wk_old;
    logic [NUM_AN-1:0]   an_s1;
    logic [NUM_AN-1:0]   an_s2;
    logic [NUM_AN-1:0]   an_old;
    logic [1:0]          warm;
    logic                irq_n;
    logic                bus_off;
  } scip_regs_t;

  scip_regs_t regs_ff;
  scip_regs_t nxt_regs;

  logic [NUM_AN-1:0] an_raw;
  logic [NUM_AN-1:0] an_now;
  logic [NUM_AN-1:0] an_was;
  logic              aux_tmo_now;
  logic              aux_tmo_was;
  logic              ana_tmo_now;
  logic              ana_tmo_was;
  logic              sync_ok;
  logic              frame_crc_bad;
  logic              frame_clk_bad;
  logic              frame_req_bad;
  logic              frame_par_bad;
  logic [NUM_EV-1:0] ev;

  // Rising edge of a synchronised level
  function automatic logic rise(input logic now, input logic old);
    rise = now & ~old;
  endfunction

  // Either edge of a synchronised level
  function automatic logic flip(input logic now, input logic old);
    flip = now ^ old;
  endfunction

  // Pin levels into the synchroniser
  always_comb begin
    an_raw                = '0;
    an_raw[AN_BAT_UV]     = i_battery_sense_undervoltage;
    an_raw[AN_SUP_LOW]    = i_supply_input_low;
    an_raw[AN_AUX_TMO]    = i_aux_rail_limit_timeout;
    an_raw[AN_ANA_TMO]    = i_analog_rail_limit_timeout;
    an_raw[AN_BUS_TSD]    = i_bus_supply_thermal_shutdown;
    an_raw[AN_PRE_TW]     = i_prereg_temp_warning;
    an_raw[AN_CORE_TW]    = i_core_reg_temp_warning;
    an_raw[AN_ANA_TW]     = i_analog_rail_temp_warning;
    an_raw[AN_BOB]        = i_prereg_buck_boost_state;
    an_raw[AN_PRE_EN]     = i_prereg_enabled;
    an_raw[AN_CORE_EN]    = i_core_reg_enabled;
    an_raw[AN_BUS_WAKE]   = i_bus_wake_event;
    an_raw[AN_TXD_DOM]    = i_txd_dominant_clamp;
    an_raw[AN_RXD_REC]    = i_rxd_recessive_clamp;
    an_raw[AN_BUS_DOM]    = i_bus_dominant_clamp;
    an_raw[AN_SHORT0]     = i_low_wire_short_battery;
    an_raw[AN_SHORT0+1]   = i_low_wire_short_ground;
    an_raw[AN_SHORT0+2]   = i_high_wire_short_battery;
    an_raw[AN_SHORT0+3]   = i_high_wire_short_ground;
    an_raw[AN_EXT_PASS]   = i_ext_pass_used;
  end

  // Limit timeouts count only with the external pass device
  assign an_now      = regs_ff.an_s2;
  assign an_was      = regs_ff.an_old;
  assign aux_tmo_now = an_now[AN_AUX_TMO] & an_now[AN_EXT_PASS];
  assign aux_tmo_was = an_was[AN_AUX_TMO] & an_was[AN_EXT_PASS];
  assign ana_tmo_now = an_now[AN_ANA_TMO] & an_now[AN_EXT_PASS];
  assign ana_tmo_was = an_was[AN_ANA_TMO] & an_was[AN_EXT_PASS];
  assign sync_ok     = (regs_ff.warm == WARM_DONE);

  // Serial frame checks at frame end
  assign frame_crc_bad = i_frame_done & i_secure_bad;
  assign frame_clk_bad = i_frame_done & i_main_state & (i_frame_clocks != SPI_BITS_V);
  assign frame_req_bad = i_frame_done & i_access_bad;
  assign frame_par_bad = i_frame_done & i_main_state & i_parity_bad;

  // Event detection
  always_comb begin
    ev                 = '0;
    ev[EV_BAT_UV]      = rise(an_now[AN_BAT_UV], an_was[AN_BAT_UV]);
    ev[EV_SUP_LOW]     = rise(an_now[AN_SUP_LOW], an_was[AN_SUP_LOW]);
    ev[EV_AUX_TMO]     = rise(aux_tmo_now, aux_tmo_was);
    ev[EV_ANA_TMO]     = rise(ana_tmo_now, ana_tmo_was);
    ev[EV_BUS_TSD]     = rise(an_now[AN_BUS_TSD], an_was[AN_BUS_TSD]);
    ev[EV_PRE_TW]      = rise(an_now[AN_PRE_TW], an_was[AN_PRE_TW]);
    ev[EV_CORE_TW]     = rise(an_now[AN_CORE_TW], an_was[AN_CORE_TW]);
    ev[EV_ANA_TW]      = rise(an_now[AN_ANA_TW], an_was[AN_ANA_TW]);
    ev[EV_BOB_CHG]     = flip(an_now[AN_BOB], an_was[AN_BOB]);
    ev[EV_PRE_EN_CHG]  = flip(an_now[AN_PRE_EN], an_was[AN_PRE_EN]);
    ev[EV_CORE_EN_CHG] = flip(an_now[AN_CORE_EN], an_was[AN_CORE_EN]);
    ev[EV_BUS_WAKE]    = rise(an_now[AN_BUS_WAKE], an_was[AN_BUS_WAKE]);
    ev[EV_TXD_DOM]     = rise(an_now[AN_TXD_DOM], an_was[AN_TXD_DOM]);
    ev[EV_RXD_REC]     = rise(an_now[AN_RXD_REC], an_was[AN_RXD_REC]);
    ev[EV_BUS_DOM]     = rise(an_now[AN_BUS_DOM], an_was[AN_BUS_DOM]);
    for (int k = 0; k < NUM_SHORT; k++) begin
      ev[EV_SHORT0+k] = rise(an_now[AN_SHORT0+k], an_was[AN_SHORT0+k]);
    end
    for (int k = 0; k < NUM_GP; k++) begin
      ev[EV_GP_CHG0+k]  = flip(regs_ff.gp_s2[k], regs_ff.gp_old[k]);
      ev[EV_GP_WAKE0+k] = rise(regs_ff.wk_s2[k], regs_ff.wk_old[k]);
    end
    if (!sync_ok) begin
      ev = '0;
    end
    ev[EV_INT_REQ]     = i_irq_request;
    ev[EV_SPI_CRC]     = frame_crc_bad;
    ev[EV_SPI_CLK]     = frame_clk_bad;
    ev[EV_SPI_REQ]     = frame_req_bad;
    ev[EV_SPI_PAR]     = frame_par_bad;
  end

  // Next state
  always_comb begin
    nxt_regs        = regs_ff;
    nxt_regs.gp_s1  = i_gp_line;
    nxt_regs.gp_s2  = regs_ff.gp_s1;
    nxt_regs.gp_old = regs_ff.gp_s2;
    nxt_regs.wk_s1  = i_gp_line_wake;
    nxt_regs.wk_s2  = regs_ff.wk_s1;
    nxt_regs.wk_old = regs_ff.wk_s2;
    nxt_regs.an_s1  = an_raw;
    nxt_regs.an_s2  = regs_ff.an_s1;
    nxt_regs.an_old = regs_ff.an_s2;
    if (!sync_ok) begin
      nxt_regs.warm = regs_ff.warm + 2'h1;
    end
    nxt_regs.bus_off = regs_ff.an_s2[AN_BUS_TSD];
    // Hold flags until read; a new event wins over the read
    nxt_regs.flags = (regs_ff.flags & ~i_status_read) | ev;
    if (i_init_phase && i_cfg_write) begin
      nxt_regs.dis = i_cfg_disable;
      nxt_regs.len = (i_cfg_pulse_len == '0) ? PULSE_W'(1) : i_cfg_pulse_len;
    end
    nxt_regs.pend = regs_ff.pend | (ev & ~i_mask);
    unique case (regs_ff.st)
      ST_IDLE: begin
        nxt_regs.irq_n = 1'b1;
        if (regs_ff.pend != '0) begin
          nxt_regs.pend  = ev & ~i_mask;
          if (!regs_ff.dis) begin
            nxt_regs.st    = ST_PULSE;
            nxt_regs.irq_n = 1'b0;
            nxt_regs.cnt   = regs_ff.len;
          end
        end
      end
      ST_PULSE: begin
        nxt_regs.cnt = regs_ff.cnt - PULSE_W'(1);
        if (regs_ff.cnt == PULSE_W'(1)) begin
          nxt_regs.st    = ST_GAP;
          nxt_regs.irq_n = 1'b1;
        end
      end
      ST_GAP: begin
        nxt_regs.st    = ST_IDLE;
        nxt_regs.irq_n = 1'b1;
      end
      default: begin
        nxt_regs.st    = ST_IDLE;
        nxt_regs.irq_n = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      regs_ff.st      <= ST_IDLE;
      regs_ff.cnt     <= '0;
      regs_ff.len     <= P_PULSE_DEF;
      regs_ff.dis     <= 1'b0;
      regs_ff.flags   <= '0;
      regs_ff.pend    <= '0;
      regs_ff.gp_s1   <= '0;
      regs_ff.gp_s2   <= '0;
      regs_ff.gp_old  <= '0;
      regs_ff.wk_s1   <= '0;
      regs_ff.wk_s2   <= '0;
      regs_ff.wk_old  <= '0;
      regs_ff.an_s1   <= '0;
      regs_ff.an_s2   <= '0;
      regs_ff.an_old  <= '0;
      regs_ff.warm    <= '0;
      regs_ff.irq_n   <= 1'b1;
      regs_ff.bus_off <= 1'b0;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  assign o_irq_out_n      = regs_ff.irq_n;
  assign o_flags          = regs_ff.flags;
  assign o_bus_supply_off = regs_ff.bus_off;

endmodule : scip_core
`default_nettype wire

/* File: inc/scip_pkg.sv */
package scip_pkg;
  // Event vector layout
  localparam int EV_BAT_UV      = 0;
  localparam int EV_SUP_LOW     = 1;
  localparam int EV_AUX_TMO     = 2;
  localparam int EV_ANA_TMO     = 3;
  localparam int EV_BUS_TSD     = 4;
  localparam int EV_PRE_TW      = 5;
  localparam int EV_CORE_TW     = 6;
  localparam int EV_ANA_TW      = 7;
  localparam int EV_BOB_CHG     = 8;
  localparam int EV_PRE_EN_CHG  = 9;
  localparam int EV_CORE_EN_CHG = 10;
  localparam int EV_BUS_WAKE    = 11;
  localparam int EV_TXD_DOM     = 12;
  localparam int EV_RXD_REC     = 13;
  localparam int EV_BUS_DOM     = 14;
  localparam int EV_SHORT0      = 15;
  localparam int EV_INT_REQ     = 19;
  localparam int EV_SPI_CRC     = 20;
  localparam int EV_SPI_CLK     = 21;
  localparam int EV_SPI_REQ     = 22;
  localparam int EV_SPI_PAR     = 23;
  localparam int EV_GP_CHG0     = 24;
  localparam int EV_GP_WAKE0    = 30;
  localparam int NUM_EV         = 36;
  localparam int NUM_SHORT      = 4;
  localparam int NUM_GP         = 6;
  localparam int PULSE_W        = 8;
  localparam int SPI_BITS       = 16;
  localparam logic [PULSE_W-1:0] PULSE_DEF = 8'h0A;
  localparam logic [4:0]         SPI_BITS_V = 5'h10;
  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_GAP} scip_state_t;
endpackage : scip_pkg

/* File: verification/scip_core_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module scip_core_monitor
  import scip_pkg::*;
(
  input wire logic              i_clock,
  input wire logic              i_rst_n,
  input wire logic              i_irq_request,
  input wire logic              i_frame_done,
  input wire logic [4:0]        i_frame_clocks,
  input wire logic              i_main_state,
  input wire logic              i_parity_bad,
  input wire logic              i_access_bad,
  input wire logic              i_bus_supply_thermal_shutdown,
  input wire logic [NUM_GP-1:0] i_gp_line,
  input wire logic              i_cfg_disable,
  input wire logic [NUM_EV-1:0] i_mask,
  input wire logic [NUM_EV-1:0] i_status_read,
  input wire logic              o_irq_out_n,
  input wire logic [NUM_EV-1:0] o_flags,
  input wire logic              o_bus_supply_off
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_req_flag: assert property (i_irq_request |=> o_flags[EV_INT_REQ])
    else $error("request flag not set");
  a_req_pulse: assert property (i_irq_request && !i_mask[EV_INT_REQ] && !i_cfg_disable
    |-> ##[2:300] !o_irq_out_n) else $error("no pulse after request");
  a_clk_count: assert property (i_frame_done && i_main_state && i_frame_clocks != SPI_BITS_V
    |=> o_flags[EV_SPI_CLK]) else $error("clock count error missed");
  a_parity_flag: assert property (i_parity_bad && i_main_state |=> o_flags[EV_SPI_PAR])
    else $error("parity error missed");
  a_access_flag: assert property (i_access_bad |=> o_flags[EV_SPI_REQ])
    else $error("access error missed");
  a_flag_sticky: assert property (1'b1 |=> ($past(o_flags) & ~$past(i_status_read) & ~o_flags)
    == '0) else $error("flag lost without read");
  a_gap_high: assert property ($rose(o_irq_out_n) |=> o_irq_out_n)
    else $error("pulse restarted at once");
  a_fall_cause: assert property ($fell(o_irq_out_n) |-> $past(|(o_flags & ~i_mask)))
    else $error("pulse without unmasked flag");
  a_gp_flag: assert property ($changed(i_gp_line[0]) |-> ##[2:6] o_flags[EV_GP_CHG0])
    else $error("line change missed");
  a_off_follow: assert property (i_bus_supply_thermal_shutdown |-> ##[1:6] o_bus_supply_off)
    else $error("bus supply not off");
endmodule // scip_core_monitor
bind scip_core scip_core_monitor scip_core_monitor_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_irq_request(i_irq_request), .i_frame_done(i_frame_done), .i_frame_clocks(i_frame_clocks),
  .i_main_state(i_main_state), .i_parity_bad(i_parity_bad), .i_access_bad(i_access_bad),
  .i_bus_supply_thermal_shutdown(i_bus_supply_thermal_shutdown), .i_gp_line(i_gp_line),
  .i_cfg_disable(i_cfg_disable), .i_mask(i_mask), .i_status_read(i_status_read),
  .o_irq_out_n(o_irq_out_n), .o_flags(o_flags), .o_bus_supply_off(o_bus_supply_off));
`default_nettype wire

/* File: verification/scip_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module scip_host_model (
  input  wire logic i_clock,
  output logic      o_frame_done,
  output logic [4:0] o_frame_clocks,
  output logic      o_main_state,
  output logic      o_parity_bad,
  output logic      o_secure_bad,
  output logic      o_access_bad
);
  initial {o_frame_done, o_frame_clocks, o_main_state, o_parity_bad, o_secure_bad,
    o_access_bad} = '0;
  // One frame: clock count plus {main, parity, secure, access} faults
  task automatic frame(input logic [4:0] c, input logic [3:0] e);
    @(negedge i_clock);
    {o_main_state, o_parity_bad, o_secure_bad, o_access_bad} = e;
    o_frame_clocks = c;
    o_frame_done = 1'b1;
    @(negedge i_clock);
    {o_frame_done, o_parity_bad, o_secure_bad, o_access_bad} = '0;
    o_frame_clocks = ~c;
  endtask
endmodule // scip_host_model
`default_nettype wire

/* File: verification/supply_chip_interrupt_pulse_test.sv */
`timescale 1ns/10ps
`default_nettype none
module supply_chip_interrupt_pulse_test;
  import scip_pkg::*;
  logic              i_clock, i_rst_n, req, iph, cw, dis, fd, ms, pb, sb, ab, irq_n, bso;
  logic [4:0]        fc, c;
  logic [3:0]        e;
  logic [7:0]        plen, pl;
  logic [19:0]       a;
  logic [NUM_GP-1:0] gp, gw;
  logic [NUM_EV-1:0] msk, srd, flags, lo;
  logic [31:0]       rs = 32'hE249, r;
  int                fails, n_checks, i, n, n2;
  scip_core #(.P_PULSE_DEF(8'h0A)) scip_core_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_battery_sense_undervoltage(a[0]), .i_supply_input_low(a[1]), .i_ext_pass_used(a[2]),
    .i_aux_rail_limit_timeout(a[3]), .i_analog_rail_limit_timeout(a[4]),
    .i_bus_supply_thermal_shutdown(a[5]), .i_prereg_temp_warning(a[6]),
    .i_core_reg_temp_warning(a[7]), .i_analog_rail_temp_warning(a[8]),
    .i_prereg_buck_boost_state(a[9]), .i_prereg_enabled(a[10]), .i_core_reg_enabled(a[11]),
    .i_bus_wake_event(a[12]), .i_txd_dominant_clamp(a[13]), .i_rxd_recessive_clamp(a[14]),
    .i_bus_dominant_clamp(a[15]), .i_low_wire_short_battery(a[16]),
    .i_low_wire_short_ground(a[17]), .i_high_wire_short_battery(a[18]),
    .i_high_wire_short_ground(a[19]), .i_gp_line(gp), .i_gp_line_wake(gw),
    .i_irq_request(req), .i_frame_done(fd), .i_frame_clocks(fc), .i_main_state(ms),
    .i_parity_bad(pb), .i_secure_bad(sb), .i_access_bad(ab), .i_init_phase(iph),
    .i_cfg_write(cw), .i_cfg_disable(dis), .i_cfg_pulse_len(pl), .i_mask(msk),
    .i_status_read(srd), .o_irq_out_n(irq_n), .o_flags(flags), .o_bus_supply_off(bso));
  scip_host_model scip_host_model_inst (.i_clock(i_clock), .o_frame_done(fd),
    .o_frame_clocks(fc), .o_main_state(ms), .o_parity_bad(pb), .o_secure_bad(sb),
    .o_access_bad(ab));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [NUM_EV-1:0] exp_spi(input logic [4:0] k, input logic [3:0] f);
    return {12'h0, f[3] & f[2], f[0], f[3] & (k != 5'h10), f[1], 20'h0};
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge i_clock);
  endtask
  task automatic chk(input logic [NUM_EV-1:0] seen, input logic [NUM_EV-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict(input bit hang);
    if (hang) fails++;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic pulse_len(output int k);
    for (k = 0; k < 300 && irq_n !== 1'b0; k++) cyc(1);
    if (k == 300) print_verdict(1'b1);
    for (k = 0; k < 300 && irq_n === 1'b0; k++) cyc(1);
  endtask
  task automatic quiet();
    lo = '0;
    req = 1'b1;
    for (int k = 0; k < 40; k++) begin
      cyc(1);
      req = 1'b0;
      lo = lo | NUM_EV'(!irq_n);
    end
  endtask
  task automatic clr();
    srd = '1;
    cyc(1);
    srd = '0;
  endtask
  initial begin
    {i_rst_n, req, cw, dis, srd, msk, gp, gw} = '0;
    a = 20'h4;
    iph = 1'b1;
    plen = 8'(rnd() % 10 + 3);
    pl = plen;
    cyc(2);
    i_rst_n = 1'b1;
    cyc(2);
    cw = 1'b1;
    cyc(1);
    {cw, iph} = '0;
    pl = plen + 8'h05;
    for (i = 0; i < 2; i++) begin
      cw = 1'(i);
      req = 1'b1;
      cyc(1);
      {req, cw} = '0;
      fork
        pulse_len(n);
        begin
          cyc(4);
          req = 1'(i);
          cyc(1);
          req = 1'b0;
        end
      join
      chk(NUM_EV'(n), NUM_EV'(plen));
      if (i == 1) pulse_len(n2);
      if (i == 1) chk(NUM_EV'(n2), NUM_EV'(plen));
      cyc(20);
    end
    msk[EV_INT_REQ] = 1'b1;
    clr();
    quiet();
    chk(lo, '0);
    msk = '0;
    for (i = 0; i < 20; i++) if (i != 2) begin
      clr();
      a[i] = 1'b1;
      cyc(40);
      chk(flags, NUM_EV'(1) << (i < 2 ? i : i - 1));
      chk(NUM_EV'(bso), NUM_EV'(i == 5));
      a[i] = 1'b0;
      cyc(40);
    end
    repeat (8) begin
      clr();
      r = rnd();
      gp ^= r[5:0];
      gw = r[11:6];
      cyc(40);
      chk(flags, {r[11:6], r[5:0], 24'h0});
      gw = '0;
    end
    for (i = 0; i < 8; i++) begin
      cyc(40);
      clr();
      r = rnd();
      c = (i == 0) ? 5'h10 : (i == 1) ? 5'h0F : (i == 2) ? 5'h11 : r[8:4];
      e = (i < 3) ? 4'h8 : r[3:0];
      scip_host_model_inst.frame(c, e);
      cyc(10);
      chk(flags, exp_spi(c, e));
    end
    i_rst_n = 1'b0;
    cyc(2);
    {i_rst_n, iph, dis, cw} = 4'hF;
    cyc(1);
    {iph, cw} = '0;
    cyc(10);
    chk(flags, '0);
    quiet();
    chk(lo, '0);
    chk(flags, NUM_EV'(1) << EV_INT_REQ);
    print_verdict(1'b0);
  end
endmodule // supply_chip_interrupt_pulse_test
`default_nettype wire
